/* File: pkg/pmic_lock_sleep_map.vh */
// register offsets, fields, reset values and timing counts of the lock and sleep register group
// Behaviour
// - watchdog lock bit one makes watchdog configuration registers read-only.
// - bits 2..5 one switch outputs two to five off in low power.
// - low_power_request requests low power; cleared when state leaves sleep.
// - deep overvoltage field bits 7:6; only 00 (+15%) valid.
// - deep undervoltage field bits 5:4 decodes -25,-20,-15,-10 percent.
// - per-output window field: 01 six, 10 eight, 11 ten percent; 00 reserved.
// - output five window in deep register 1:0; outputs four..one in second register.
// - sleep pin ignored for blanking time after reset output rises.
// - wake only after sleep pin high for selected rise deglitch time.
// - enter low power only after sleep pin low for fall deglitch time.
// - global write lock one ignores writes to protected registers; lock stays writable.
// - state field bits 3:0 report idle through power-up codes 0000..0111.
// - state field reports 1100 recover, 1101 reset, 1110 recovery-reset.
// - bit 7 of state register shows fuse CRC failure.
// - bit 6 shows analog self-test fail, bit 5 logic self-test fail.
`ifndef PMIC_LOCK_SLEEP_MAP_VH
`define PMIC_LOCK_SLEEP_MAP_VH
// ****************************************
// register offsets
// ****************************************
`define WD_CFG_FIRST 8'h13
`define WD_CFG_LAST 8'h16
`define OFS_WDOG_LOCK 8'h17
`define OFS_LP_SELECT 8'h18
`define OFS_DEEP_THR 8'h19
`define OFS_WIN_THR 8'h1A
`define OFS_SLEEP_TIME 8'h1B
`define OFS_BUS_LOCK 8'h1C
`define OFS_STATE_CODE 8'h22
// ****************************************
// writable bit masks and reset values
// ****************************************
`define MASK_WDOG_LOCK 8'h01
`define MASK_LP_SELECT 8'h3D
`define MASK_DEEP_THR 8'hF3
`define MASK_WIN_THR 8'hFF
`define MASK_SLEEP_TIME 8'hFF
`define MASK_BUS_LOCK 8'h01
`define RST_WDOG_LOCK 8'h00
`define RST_LP_SELECT 8'h00
`define RST_DEEP_THR 8'h01
`define RST_WIN_THR 8'h55
`define RST_SLEEP_TIME 8'h00
`define RST_BUS_LOCK 8'h00
// ****************************************
// state codes
// ****************************************
`define STATE_SLEEP 4'h4
// ****************************************
// timing at 25 MHz
// ****************************************
`define CLK_MHZ 25
`define BLANK_2P5MS_US 2500
`define BLANK_5MS_US 5000
`define BLANK_10MS_US 10000
`define DG_100US 100
`define DG_50US 50
`define DG_20US 20
`define DG_10US 10
`define CYC_BLANK_2P5MS (`BLANK_2P5MS_US * `CLK_MHZ)
`define CYC_BLANK_5MS (`BLANK_5MS_US * `CLK_MHZ)
`define CYC_BLANK_10MS (`BLANK_10MS_US * `CLK_MHZ)
`define CYC_DG_100US (`DG_100US * `CLK_MHZ)
`define CYC_DG_50US (`DG_50US * `CLK_MHZ)
`define CYC_DG_20US (`DG_20US * `CLK_MHZ)
`define CYC_DG_10US (`DG_10US * `CLK_MHZ)
`endif

/* File: hdl/sleep_pin_deglitch.v */
// low-to-high and high-to-low deglitch of the sleep request pin
`timescale 1ns/1ps
`default_nettype none
`include "pmic_lock_sleep_map.vh"
module sleep_pin_deglitch #(
  parameter CNT_W = 12
) (
  // clock and reset
  input wire sys_clk_in,
  input wire reset_in,
  // pin and timing selects
  input wire pin_in,
  input wire [1:0] rise_sel_in,
  input wire [1:0] fall_sel_in,
  // filtered level
  output reg level_out
);
  // counts kept 32 bits wide here and cut to the counter width below
  localparam [31:0] LIM_100 = `CYC_DG_100US;
  localparam [31:0] LIM_50 = `CYC_DG_50US;
  localparam [31:0] LIM_20 = `CYC_DG_20US;
  localparam [31:0] LIM_10 = `CYC_DG_10US;
  reg [CNT_W-1:0] cnt_r;
  reg [CNT_W-1:0] limit;
  reg [1:0] sel;

  always @* begin
    sel = level_out ? fall_sel_in : rise_sel_in;
    case (sel)
      2'b00: limit = LIM_100[CNT_W-1:0];
      2'b01: limit = LIM_50[CNT_W-1:0];
      2'b10: limit = LIM_20[CNT_W-1:0];
      default: limit = LIM_10[CNT_W-1:0];
    endcase
  end

  // counter restarts on every bounce, so only a steady level passes
  always @(posedge sys_clk_in) begin
    if (reset_in) begin
      cnt_r <= {CNT_W{1'b0}};
      level_out <= 1'b1;
    end else if (pin_in == level_out) begin
      cnt_r <= {CNT_W{1'b0}};
    end else if (cnt_r >= limit - 1'b1) begin
      cnt_r <= {CNT_W{1'b0}};
      level_out <= pin_in;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end
endmodule
`default_nettype wire

/* File: hdl/sleep_blanking_timer.v */
// blanking window after the system reset output rises
`timescale 1ns/1ps
`default_nettype none
`include "pmic_lock_sleep_map.vh"
module sleep_blanking_timer #(
  parameter CNT_W = 18,
  parameter CYC_2P5 = `CYC_BLANK_2P5MS,
  parameter CYC_5 = `CYC_BLANK_5MS,
  parameter CYC_10 = `CYC_BLANK_10MS
) (
  // clock and reset
  input wire sys_clk_in,
  input wire reset_in,
  // trigger and select
  input wire reset_rise_in,
  input wire [1:0] blank_sel_in,
  // window active
  output reg blanking_out
);
  reg [CNT_W-1:0] cnt_r;
  reg [CNT_W-1:0] len;

  always @* begin
    case (blank_sel_in)
      2'b01: len = CYC_2P5[CNT_W-1:0];
      2'b10: len = CYC_5[CNT_W-1:0];
      2'b11: len = CYC_10[CNT_W-1:0];
      default: len = {CNT_W{1'b0}};
    endcase
  end

  always @(posedge sys_clk_in) begin
    if (reset_in) begin
      cnt_r <= {CNT_W{1'b0}};
      blanking_out <= 1'b0;
    end else if (reset_rise_in) begin
      cnt_r <= len;
      blanking_out <= (len != {CNT_W{1'b0}});
    end else if (cnt_r > {{(CNT_W-1){1'b0}}, 1'b1}) begin
      cnt_r <= cnt_r - 1'b1;
    end else begin
      cnt_r <= {CNT_W{1'b0}};
      blanking_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: hdl/pmic_lock_sleep_state_regs.v */
// lock, low-power, threshold, sleep timing and state register group
`timescale 1ns/1ps
`default_nettype none
`include "pmic_lock_sleep_map.vh"
module pmic_lock_sleep_state_regs #(
  parameter BLANK_CNT_W = 18,
  parameter CYC_BLANK_2P5 = `CYC_BLANK_2P5MS,
  parameter CYC_BLANK_5 = `CYC_BLANK_5MS,
  parameter CYC_BLANK_10 = `CYC_BLANK_10MS
) (
  // clock and reset
  input wire sys_clk_in,
  input wire reset_in,
  // register port from the bus engine
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg [7:0] reg_rdata_out,
  output reg reg_rdata_valid_out,
  // sleep pin and reset output level
  input wire sleep_request_pin_in,
  input wire system_reset_out_in,
  // state machine status
  input wire [3:0] state_code_in,
  input wire fuse_crc_fail_in,
  input wire analog_selftest_fail_in,
  input wire logic_selftest_fail_in,
  // controls to the rest of the device
  output reg watchdog_cfg_wr_en_out,
  output reg [3:0] outs_lowpower_off_out,
  output reg low_power_request_out,
  output reg [1:0] deep_overvoltage_level_out,
  output reg deep_overvoltage_valid_out,
  output reg [1:0] deep_undervoltage_level_out,
  output reg [9:0] out_window_level_out,
  output reg [4:0] out_window_valid_out,
  output reg sleep_entry_out
);
  // ****************************************
  // storage
  // ****************************************
  reg [7:0] wdog_lock_r;
  reg [7:0] lp_select_r;
  reg [7:0] deep_thr_r;
  reg [7:0] win_thr_r;
  reg [7:0] sleep_time_r;
  reg [7:0] bus_lock_r;
  reg [3:0] state_prev_r;
  reg rst_prev_r;
  wire watchdog_lock_bit;
  wire bus_locked;
  wire wr_ok;
  wire leave_sleep;
  wire reset_rise;
  wire blanking;
  wire sleep_filtered;
  wire [9:0] win_all;
  wire [7:0] lp_wdata;
  reg [7:0] rd_mux;

  assign watchdog_lock_bit = wdog_lock_r[0];
  assign bus_locked = bus_lock_r[0];
  assign wr_ok = reg_wr_in & ~bus_locked;
  assign leave_sleep = (state_prev_r == `STATE_SLEEP) && (state_code_in != `STATE_SLEEP);
  assign reset_rise = system_reset_out_in & ~rst_prev_r;
  assign win_all = {deep_thr_r[1:0], win_thr_r};
  assign lp_wdata = reg_wdata_in & `MASK_LP_SELECT;

  // ****************************************
  // register writes
  // ****************************************
  always @(posedge sys_clk_in) begin
    if (reset_in) begin
      wdog_lock_r <= `RST_WDOG_LOCK;
      lp_select_r <= `RST_LP_SELECT;
      deep_thr_r <= `RST_DEEP_THR;
      win_thr_r <= `RST_WIN_THR;
      sleep_time_r <= `RST_SLEEP_TIME;
      bus_lock_r <= `RST_BUS_LOCK;
      state_prev_r <= 4'h0;
      rst_prev_r <= 1'b0;
    end else begin
      state_prev_r <= state_code_in;
      rst_prev_r <= system_reset_out_in;
      // lock register stays reachable so software can unlock
      if (reg_wr_in && reg_addr_in == `OFS_BUS_LOCK) begin
        bus_lock_r <= reg_wdata_in & `MASK_BUS_LOCK;
      end
      if (wr_ok && reg_addr_in == `OFS_WDOG_LOCK) begin
        wdog_lock_r <= reg_wdata_in & `MASK_WDOG_LOCK;
      end
      if (wr_ok && reg_addr_in == `OFS_DEEP_THR) begin
        deep_thr_r <= reg_wdata_in & `MASK_DEEP_THR;
      end
      if (wr_ok && reg_addr_in == `OFS_WIN_THR) begin
        win_thr_r <= reg_wdata_in & `MASK_WIN_THR;
      end
      if (wr_ok && reg_addr_in == `OFS_SLEEP_TIME) begin
        sleep_time_r <= reg_wdata_in & `MASK_SLEEP_TIME;
      end
      // self-clear wins over a write in the same cycle: leaving sleep is final
      if (leave_sleep) begin
        lp_select_r[0] <= 1'b0;
        if (wr_ok && reg_addr_in == `OFS_LP_SELECT) begin
          lp_select_r[7:1] <= lp_wdata[7:1];
        end
      end else if (wr_ok && reg_addr_in == `OFS_LP_SELECT) begin
        lp_select_r <= lp_wdata;
      end
    end
  end

  // ****************************************
  // sleep pin handling
  // ****************************************
  sleep_blanking_timer #(
    .CNT_W(BLANK_CNT_W),
    .CYC_2P5(CYC_BLANK_2P5),
    .CYC_5(CYC_BLANK_5),
    .CYC_10(CYC_BLANK_10)
  ) u_blank (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .reset_rise_in(reset_rise),
    .blank_sel_in(sleep_time_r[5:4]),
    .blanking_out(blanking)
  );

  sleep_pin_deglitch #(
    .CNT_W(12)
  ) u_deglitch (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .pin_in(sleep_request_pin_in),
    .rise_sel_in(sleep_time_r[3:2]),
    .fall_sel_in(sleep_time_r[1:0]),
    .level_out(sleep_filtered)
  );

  // ****************************************
  // read mux, reserved bits zero
  // ****************************************
  always @* begin
    case (reg_addr_in)
      `OFS_WDOG_LOCK: rd_mux = wdog_lock_r;
      `OFS_LP_SELECT: rd_mux = lp_select_r;
      `OFS_DEEP_THR: rd_mux = deep_thr_r;
      `OFS_WIN_THR: rd_mux = win_thr_r;
      `OFS_SLEEP_TIME: rd_mux = sleep_time_r;
      `OFS_BUS_LOCK: rd_mux = bus_lock_r;
      `OFS_STATE_CODE: rd_mux = {fuse_crc_fail_in, analog_selftest_fail_in,
        logic_selftest_fail_in, 1'b0, state_code_in};
      default: rd_mux = 8'h00;
    endcase
  end

  // ****************************************
  // registered outputs
  // ****************************************
  integer i;
  always @(posedge sys_clk_in) begin
    if (reset_in) begin
      reg_rdata_out <= 8'h00;
      reg_rdata_valid_out <= 1'b0;
      watchdog_cfg_wr_en_out <= 1'b1;
      outs_lowpower_off_out <= 4'h0;
      low_power_request_out <= 1'b0;
      deep_overvoltage_level_out <= 2'b00;
      deep_overvoltage_valid_out <= 1'b1;
      deep_undervoltage_level_out <= 2'b00;
      out_window_level_out <= 10'h000;
      out_window_valid_out <= 5'h00;
      sleep_entry_out <= 1'b0;
    end else begin
      reg_rdata_valid_out <= reg_rd_in;
      if (reg_rd_in) begin
        reg_rdata_out <= rd_mux;
      end
      // watchdog config writes pass only when both locks are open
      watchdog_cfg_wr_en_out <= ~watchdog_lock_bit & ~bus_locked;
      outs_lowpower_off_out <= lp_select_r[5:2];
      low_power_request_out <= lp_select_r[0];
      deep_overvoltage_level_out <= deep_thr_r[7:6];
      deep_overvoltage_valid_out <= (deep_thr_r[7:6] == 2'b00);
      deep_undervoltage_level_out <= deep_thr_r[5:4];
      out_window_level_out <= win_all;
      for (i = 0; i < 5; i = i + 1) begin
        out_window_valid_out[i] <= (win_all[2*i +: 2] != 2'b00);
      end
      // pin ignored while blanking; host must raise it in time
      // blanking flop starts one edge late, so the rise edge itself blocks too
      sleep_entry_out <= ~blanking & ~reset_rise & ~sleep_filtered & system_reset_out_in;
    end
  end
endmodule
`default_nettype wire

/* File: testbench/pmic_lock_sleep_state_regs_chk.sv */
// assertion checker on the register group ports
`timescale 1ns/1ps
`default_nettype none
module pmic_lock_sleep_state_regs_chk (
  input wire logic sys_clk_in, reset_in, reg_wr_in, reg_rd_in,
  input wire logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out,
  input wire logic sleep_request_pin_in, system_reset_out_in, fuse_crc_fail_in,
  input wire logic analog_selftest_fail_in, logic_selftest_fail_in, watchdog_cfg_wr_en_out,
  input wire logic [3:0] state_code_in, outs_lowpower_off_out,
  input wire logic low_power_request_out, deep_overvoltage_valid_out, sleep_entry_out,
  input wire logic [1:0] deep_overvoltage_level_out, deep_undervoltage_level_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  // pin run lengths, saturating so a long idle never wraps
  logic [11:0] lo_c, hi_c;
  logic rd_st, wr17, wr18, wr18s, wr19, wr1c;
  assign rd_st = reg_rd_in && reg_addr_in == 8'h22;
  assign wr1c = reg_wr_in && reg_addr_in == 8'h1c && reg_wdata_in[0];
  assign wr17 = reg_wr_in && reg_addr_in == 8'h17 && reg_wdata_in[0];
  assign wr18 = reg_wr_in && reg_addr_in == 8'h18;
  assign wr18s = wr18 && reg_wdata_in[0];
  assign wr19 = reg_wr_in && reg_addr_in == 8'h19;
  always_ff @(posedge sys_clk_in) begin
    lo_c <= reset_in || sleep_request_pin_in ? 12'h000 : lo_c + 12'(~&lo_c);
    hi_c <= reset_in || !sleep_request_pin_in ? 12'h000 : hi_c + 12'(~&hi_c);
  end
  a_state_code_rd: assert property (rd_st |=> reg_rdata_out[3:0] == $past(state_code_in))
    else $error("state code wrong");
  a_fail_flags_rd: assert property (rd_st |=> reg_rdata_out[7:4] == {$past(fuse_crc_fail_in),
    $past(analog_selftest_fail_in), $past(logic_selftest_fail_in), 1'b0})
    else $error("fail flags wrong");
  a_watchdog_config_lock_cause: assert property ($fell(watchdog_cfg_wr_en_out) |-> $past(wr17 || wr1c, 2))
    else $error("watchdog lock without write");
  a_lp_off_cause: assert property ($changed(outs_lowpower_off_out) |-> $past(wr18, 2))
    else $error("low power select moved");
  a_lp_req_set: assert property ($rose(low_power_request_out) |-> $past(wr18s, 2))
    else $error("low power request rose");
  a_lp_self_clear: assert property (state_code_in == 4'h4 ##1 state_code_in != 4'h4 |->
    ##[1:3] !low_power_request_out) else $error("request not cleared");
  a_ov_valid_code: assert property (deep_overvoltage_valid_out == (deep_overvoltage_level_out == 2'h0))
    else $error("deep ov validity wrong");
  a_uv_cause: assert property ($changed(deep_undervoltage_level_out) |-> $past(wr19, 2))
    else $error("deep uv moved");
  a_sleep_fall_dg: assert property ($rose(sleep_entry_out) |-> lo_c >= 12'h0f8)
    else $error("sleep entry too early");
  a_wake_rise_dg: assert property ($fell(sleep_entry_out) && system_reset_out_in |-> hi_c >= 12'h0f8)
    else $error("wake too early");
  c_lock_set: cover property (reg_wr_in && reg_addr_in == 8'h1c && reg_wdata_in[0]);
  c_sleep_enter: cover property ($rose(sleep_entry_out));
  c_self_clear: cover property ($fell(low_power_request_out));
endmodule
bind pmic_lock_sleep_state_regs pmic_lock_sleep_state_regs_chk chk (
  .sys_clk_in(sys_clk_in), .reset_in(reset_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
  .sleep_request_pin_in(sleep_request_pin_in), .system_reset_out_in(system_reset_out_in),
  .fuse_crc_fail_in(fuse_crc_fail_in), .analog_selftest_fail_in(analog_selftest_fail_in),
  .logic_selftest_fail_in(logic_selftest_fail_in),
  .watchdog_cfg_wr_en_out(watchdog_cfg_wr_en_out), .state_code_in(state_code_in),
  .outs_lowpower_off_out(outs_lowpower_off_out), .low_power_request_out(low_power_request_out),
  .deep_overvoltage_valid_out(deep_overvoltage_valid_out), .sleep_entry_out(sleep_entry_out),
  .deep_overvoltage_level_out(deep_overvoltage_level_out),
  .deep_undervoltage_level_out(deep_undervoltage_level_out)
);
`default_nettype wire

/* File: testbench/host_mcu_model.sv */
// host controller model: register strobes and sleep pin
`timescale 1ns/1ps
`default_nettype none
module host_mcu_model (
  // clock and read return
  input wire logic sys_clk_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic reg_rdata_valid_out,
  // strobes and sleep pin
  output logic [7:0] reg_addr_in,
  output logic [7:0] reg_wdata_in,
  output logic reg_wr_in,
  output logic reg_rd_in,
  output logic sleep_request_pin_in
);
  // pin high from power-on so no sleep request is seen at reset release
  initial begin
    reg_addr_in = 8'h00;
    reg_wdata_in = 8'h00;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    sleep_request_pin_in = 1'b1;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    #1;
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1'b1;
    @(posedge sys_clk_in);
    #1;
    // idle bus shows inverted values, never stale ones
    reg_addr_in = ~a;
    reg_wdata_in = ~d;
    reg_wr_in = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk_in);
    #1;
    reg_addr_in = a;
    reg_rd_in = 1'b1;
    @(posedge sys_clk_in);
    #1;
    reg_addr_in = ~a;
    reg_rd_in = 1'b0;
    d = reg_rdata_valid_out === 1'b1 ? reg_rdata_out : 8'hxx;
  endtask
  task automatic pin(input logic v);
    @(posedge sys_clk_in);
    #1;
    sleep_request_pin_in = v;
  endtask
endmodule
`default_nettype wire

/* File: testbench/pmic_lock_sleep_state_regs_tb.sv */
// self-checking bench for the lock and sleep register group
`timescale 1ns/1ps
`default_nettype none
module pmic_lock_sleep_state_regs_tb;
  logic sys_clk_in = 1'b0, reset_in = 1'b1, system_reset_out_in = 1'b0;
  logic fuse_crc_fail_in = 1'b0, analog_selftest_fail_in = 1'b0, logic_selftest_fail_in = 1'b0;
  logic [3:0] state_code_in = 4'h0;
  wire logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out;
  wire logic reg_wr_in, reg_rd_in, reg_rdata_valid_out, sleep_request_pin_in, sleep_entry_out;
  wire logic watchdog_cfg_wr_en_out, low_power_request_out, deep_overvoltage_valid_out;
  wire logic [3:0] outs_lowpower_off_out;
  wire logic [1:0] deep_overvoltage_level_out, deep_undervoltage_level_out;
  wire logic [9:0] out_window_level_out;
  wire logic [4:0] out_window_valid_out;
  int failures = 0, checked = 0, n;
  int mdl [256];
  int dgc [4] = '{2500, 1250, 500, 250};
  always #20 sys_clk_in = ~sys_clk_in;
  host_mcu_model host (
    .sys_clk_in(sys_clk_in), .reg_rdata_out(reg_rdata_out),
    .reg_rdata_valid_out(reg_rdata_valid_out), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .sleep_request_pin_in(sleep_request_pin_in)
  );
  pmic_lock_sleep_state_regs #(.CYC_BLANK_2P5(20), .CYC_BLANK_5(40), .CYC_BLANK_10(80)) dut (
    .sys_clk_in(sys_clk_in), .reset_in(reset_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .reg_rdata_valid_out(reg_rdata_valid_out),
    .sleep_request_pin_in(sleep_request_pin_in), .system_reset_out_in(system_reset_out_in),
    .state_code_in(state_code_in), .fuse_crc_fail_in(fuse_crc_fail_in),
    .analog_selftest_fail_in(analog_selftest_fail_in),
    .logic_selftest_fail_in(logic_selftest_fail_in),
    .watchdog_cfg_wr_en_out(watchdog_cfg_wr_en_out),
    .outs_lowpower_off_out(outs_lowpower_off_out), .low_power_request_out(low_power_request_out),
    .deep_overvoltage_level_out(deep_overvoltage_level_out),
    .deep_overvoltage_valid_out(deep_overvoltage_valid_out),
    .deep_undervoltage_level_out(deep_undervoltage_level_out),
    .out_window_level_out(out_window_level_out), .out_window_valid_out(out_window_valid_out),
    .sleep_entry_out(sleep_entry_out)
  );
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cmp(string nm, int e, logic [9:0] s);
    checked++;
    if (s !== e[9:0]) begin
      failures++;
      $display("ERROR %s expected %0h seen %0h", nm, e, s);
    end
  endtask
  task automatic outs();
    int lp, dt, wl;
    lp = mdl[8'h18];
    dt = mdl[8'h19];
    wl = {dt[1:0], mdl[8'h1a][7:0]};
    cmp("wd_en", !mdl[8'h17][0] && !mdl[8'h1c][0], watchdog_cfg_wr_en_out);
    cmp("lp_off", lp[5:2], outs_lowpower_off_out);
    cmp("lp_req", lp[0], low_power_request_out);
    cmp("ov", dt[7:6], deep_overvoltage_level_out);
    cmp("ov_ok", dt[7:6] == 2'h0, deep_overvoltage_valid_out);
    cmp("uv", dt[5:4], deep_undervoltage_level_out);
    cmp("win", wl, out_window_level_out);
    for (int i = 0; i < 5; i++) cmp("win_ok", (wl >> 2 * i & 3) != 0, out_window_valid_out[i]);
  endtask
  // writes ignored by the model mirror lock and read-only places
  task automatic w(int a, int d);
    host.wr(a[7:0], d[7:0]);
    if (a == 8'h1c || (a >= 8'h17 && a < 8'h1c && !mdl[8'h1c][0])) begin
      mdl[a] = d & (a == 8'h18 ? 8'h3d : a == 8'h19 ? 8'hf3 : a > 8'h19 && a < 8'h1c ? 8'hff : 1);
    end
    @(posedge sys_clk_in);
    #1;
    outs();
  endtask
  task automatic r(int a);
    logic [7:0] v;
    host.rd(a[7:0], v);
    cmp("rdata", a == 8'h22 ? {fuse_crc_fail_in, analog_selftest_fail_in,
      logic_selftest_fail_in, 1'b0, state_code_in} : mdl[a], v);
  endtask
  task automatic wt(logic lvl);
    n = 0;
    while (sleep_entry_out !== lvl) begin
      @(posedge sys_clk_in);
      #1;
      n++;
      if (n > 4000) begin
        failures++;
        end_sim();
      end
    end
  endtask
  initial begin
    void'($urandom(32'h8122_1383));
    mdl[8'h19] = 8'h01;
    mdl[8'h1a] = 8'h55;
    repeat (20) @(posedge sys_clk_in);
    #1;
    reset_in = 1'b0;
    system_reset_out_in = 1'b1;
    // outputs follow their registers one edge after release
    @(posedge sys_clk_in);
    #1;
    outs();
    for (int a = 8'h17; a < 8'h1d; a++) r(a);
    r(8'h30);
    $display("test reset values done");
    repeat (4) for (int a = 8'h17; a < 8'h1c; a++) begin
      w(a, $urandom);
      r(a);
    end
    w(8'h22, 8'hff);
    w(8'h30, 8'hff);
    r(8'h30);
    $display("test random writes done");
    w(8'h1c, 8'h01);
    for (int a = 8'h17; a < 8'h1c; a++) begin
      w(a, ~mdl[a]);
      r(a);
    end
    r(8'h1c);
    w(8'h1c, 8'h00);
    w(8'h17, 8'h01);
    w(8'h17, 8'h00);
    w(8'h18, 8'h00);
    $display("test write lock done");
    for (int s = 0; s < 16; s++) begin
      fuse_crc_fail_in = 1'($urandom);
      analog_selftest_fail_in = 1'($urandom);
      logic_selftest_fail_in = 1'($urandom);
      state_code_in = 4'(s);
      r(8'h22);
    end
    // sleep state then a move away must drop the request bit
    w(8'h18, 8'h3d);
    state_code_in = 4'h4;
    repeat (3) @(posedge sys_clk_in);
    #1;
    state_code_in = 4'h5;
    repeat (3) @(posedge sys_clk_in);
    #1;
    mdl[8'h18] = 8'h3c;
    outs();
    r(8'h18);
    $display("test state and self clear done");
    for (int f = 0; f < 4; f++) begin
      w(8'h1b, (3 - f) << 2 | f);
      host.pin(1'b0);
      wt(1'b1);
      cmp("fall_dg", 1, n >= dgc[f] - 3 && n <= dgc[f] + 3);
      host.pin(1'b1);
      wt(1'b0);
      cmp("rise_dg", 1, n >= dgc[3 - f] - 3 && n <= dgc[3 - f] + 3);
    end
    w(8'h1b, 8'h3f);
    system_reset_out_in = 1'b0;
    host.pin(1'b0);
    repeat (300) @(posedge sys_clk_in);
    #1;
    cmp("held_reset", 0, sleep_entry_out);
    system_reset_out_in = 1'b1;
    wt(1'b1);
    cmp("blank", 1, n >= 77 && n <= 84);
    host.pin(1'b1);
    wt(1'b0);
    $display("test sleep timing done");
    end_sim();
  end
endmodule
`default_nettype wire
